//--- spo_ssi_output.sv
// position output processor with register port and serial output
//
// Our own choices: the address map and the plain strobed port.
`timescale 1ns/10ps
module spo_ssi_output
    import spo_pkg::*;
#(
    parameter int MS_CYCLES = MS_CYC,
    parameter logic [POS_W-1:0] STROKE = 26'h0100000
)
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire spo_meas_s meas,
    input wire logic supply_ok,
    input wire logic ssi_clk,
    output logic ssi_data,
    output logic meas_start,
    output logic reflect_excl,
    output logic nvm_store
);

    if (MS_CYCLES < 1 || MS_CYCLES > 65535)
    begin : g_chk
        $error("MS_CYCLES out of range");
    end

    // ============================================================
    // registers and state
    spo_cfg_s ctrl;
    logic [POS_W-1:0] err_value, offset, area_start, area_end, last_p1;
    logic [7:0] err_limit, err_cnt, temp_reg;
    logic [6:0] dip_ms, dip_elapsed;
    logic [15:0] ms_cnt;
    logic area_on, cfg_reject, err_active, err_m1, kick;
    logic signed [POS_W-1:0] result, delta, prev_rel;
    logic [19:0] elapsed, period;
    logic clk_m, clk_s, clk_d, sup_m, sup_s;
    spo_ssi_e state;
    logic [FRAME_W-1:0] shreg;
    logic [5:0] bit_cnt;
    logic [9:0] mono_cnt;

    // ============================================================
    // register port decode
    spo_cfg_s wr_cfg, cfg_new;
    logic ctrl_wr, ctrl_ok, cmd_wr, restore;
    assign wr_cfg = spo_cfg_s'(reg_wdata[CFG_W-1:0]);
    assign ctrl_wr = reg_wr && reg_addr == CTRL_ADDR;
    assign ctrl_ok = !(wr_cfg.parity_en && wr_cfg.temp_en) && wr_cfg.wsel != WSEL_BAD;
    assign cmd_wr = reg_wr && reg_addr == CMD_ADDR;
    assign restore = cmd_wr && reg_wdata[CMD_RESTORE];

    // mode 2 only under polled timing, mode 3 only on top of mode 2
    always_comb
    begin
        cfg_new = wr_cfg;
        cfg_new.oversampled_sync_select = wr_cfg.oversampled_sync_select
            && wr_cfg.polled_timing_select;
        cfg_new.sync3 = wr_cfg.sync3 && cfg_new.oversampled_sync_select;
    end

    // ============================================================
    // measurement classification
    function automatic logic [POS_W-1:0] dir_fix(input logic [POS_W-1:0] raw, input logic rev);
        dir_fix = rev ? STROKE - raw : raw;
    endfunction

    function automatic logic [POS_W-1:0] to_gray(input logic [POS_W-1:0] v);
        to_gray = v ^ (v >> 1);
    endfunction

    logic [POS_W-1:0] p1, p2;
    logic in_area, good, too_many, dip_hold;
    logic [1:0] mag_eff, mag_cfg;
    logic signed [POS_W-1:0] rel, sel_val;
    assign p1 = dir_fix(meas.pos1, ctrl.reverse);
    assign p2 = dir_fix(meas.pos2, ctrl.reverse);
    assign in_area = !area_on || (p1 >= area_start && p1 <= area_end);
    assign mag_eff = (!in_area && meas.magnets != 2'h0) ? meas.magnets - 2'h1 : meas.magnets;
    assign mag_cfg = (ctrl.out_sel == OUT_DIFF) ? 2'h2 : 2'h1;
    assign too_many = mag_eff > mag_cfg;
    assign good = !meas.fail && mag_eff == mag_cfg;
    assign rel = p1 - offset;
    assign sel_val = (ctrl.out_sel == OUT_DIFF) ? p2 - p1 :
                     (ctrl.out_sel == OUT_VEL) ? rel - prev_rel : rel;
    // a dip is forgiven only while the configured window lasts
    assign dip_hold = !sup_s && dip_ms != 7'h00 && dip_elapsed < dip_ms;

    logic filt_valid;
    logic signed [POS_W-1:0] filt_data;
    spo_avg_filter #(.W(POS_W), .DEPTH(8)) u_filt (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .in_valid(meas.valid && good),
        .in_data(sel_val),
        .sel(ctrl.filt),
        .out_valid(filt_valid),
        .out_data(filt_data)
    );

    // ============================================================
    // output value and frame
    logic signed [POS_W-1:0] extra, out_value;
    logic [POS_W-1:0] coded;
    logic [FRAME_W-1:0] frame;
    logic [5:0] frame_len;
    logic par;
    // mode 2 steps ahead after half a period, mode 3 always steps ahead
    assign extra = ctrl.sync3 ? delta :
                   (ctrl.oversampled_sync_select && elapsed >= (period >> 1)) ? delta :
                   '0;
    assign out_value = err_active ? (err_m1 ? '1 : err_value) : result + extra;
    // gray has no sign, so values below the null point clamp to zero
    assign coded = ctrl.gray ? to_gray(out_value[POS_W-1] ? '0 : out_value)
                             : out_value;
    assign par = ^{coded[23:0], err_active};
    assign frame = ctrl.temp_en ? {coded[23:0], temp_reg} :
                   ctrl.parity_en ? {coded[23:0], err_active, par, 6'h00} :
                   (FRAME_W'({coded, 6'h00}) << (2'h2 - ctrl.wsel));
    assign frame_len = ctrl.temp_en ? 6'd32 : ctrl.parity_en ? 6'd26
                                            : 6'd24 + 6'(ctrl.wsel);

    // ============================================================
    // synchronisers for pins
    logic fall, rise, latch, mono_end;
    assign fall = clk_d && !clk_s;
    assign rise = !clk_d && clk_s;
    assign latch = state == SSI_IDLE && fall;
    assign mono_end = state != SSI_IDLE && clk_s && mono_cnt == 10'(MONO_CYC - 1);

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            {clk_m, clk_s, clk_d} <= 3'h7;
            {sup_m, sup_s} <= 2'h3;
        end
        else
        begin
            {clk_m, clk_s, clk_d} <= {ssi_clk, clk_m, clk_s};
            {sup_m, sup_s} <= {supply_ok, sup_m};
        end
    end

    // ============================================================
    // serial shifter, clock idles high, ends on monoflop timeout
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state <= SSI_IDLE;
            shreg <= '0;
            bit_cnt <= '0;
            ssi_data <= 1'b1;
            mono_cnt <= '0;
        end
        else
        begin
            mono_cnt <= (clk_s && !rise && state != SSI_IDLE) ? mono_cnt + 10'h001 : '0;
            case (state)
                SSI_IDLE:
                begin
                    ssi_data <= 1'b1;
                    if (latch)
                    begin
                        shreg <= frame;
                        bit_cnt <= frame_len;
                        state <= SSI_SHIFT;
                    end
                end
                SSI_SHIFT:
                begin
                    if (mono_end)
                        state <= SSI_IDLE;
                    else if (rise)
                    begin
                        ssi_data <= bit_cnt != 6'h00 && shreg[FRAME_W-1];
                        shreg <= shreg << 1;
                        bit_cnt <= bit_cnt - 6'h01;
                        if (bit_cnt == 6'h00)
                            state <= SSI_TAIL;
                    end
                end
                SSI_TAIL:
                begin
                    ssi_data <= 1'b0;
                    if (mono_end)
                        state <= SSI_IDLE;
                end
                default: state <= SSI_IDLE;
            endcase
        end
    end

    // ============================================================
    // measurement scheduling and result tracking
    logic free_run;
    assign free_run = !ctrl.polled_timing_select || ctrl.oversampled_sync_select;

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            meas_start <= 1'b0;
            kick <= 1'b1;
            result <= '0;
            delta <= '0;
            prev_rel <= '0;
            elapsed <= '0;
            period <= '0;
            temp_reg <= '0;
            last_p1 <= '0;
        end
        else
        begin
            // free running restarts on each result, polled waits for the burst
            meas_start <= free_run ? (kick || meas.valid) : latch;
            kick <= 1'b0;
            elapsed <= (elapsed == '1) ? elapsed : elapsed + 20'h00001;
            if (meas.valid)
            begin
                temp_reg <= meas.temp;
                if (good)
                begin
                    prev_rel <= rel;
                    last_p1 <= p1;
                end
            end
            if (filt_valid)
            begin
                delta <= filt_data - result;
                result <= filt_data;
                period <= elapsed;
                elapsed <= '0;
            end
        end
    end

    // ============================================================
    // error repeat counter and supply dip window
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            err_cnt <= '0;
            err_active <= 1'b0;
            err_m1 <= 1'b0;
            ms_cnt <= '0;
            dip_elapsed <= '0;
        end
        else
        begin
            ms_cnt <= (sup_s || ms_cnt == 16'(MS_CYCLES - 1)) ? '0 : ms_cnt + 16'h0001;
            if (sup_s)
                dip_elapsed <= '0;
            else if (ms_cnt == 16'(MS_CYCLES - 1) && dip_elapsed != 7'h7f)
                dip_elapsed <= dip_elapsed + 7'h01;
            if (meas.valid && good)
                err_cnt <= '0;
            else if (meas.valid && !dip_hold)
            begin
                if (err_cnt >= err_limit)
                begin
                    err_active <= 1'b1;
                    err_m1 <= too_many && ctrl.second_err;
                end
                else
                    err_cnt <= err_cnt + 8'h01;
            end
            if (filt_valid)
                err_active <= 1'b0;
        end
    end

    // ============================================================
    // software registers
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl <= CTRL_RST;
            err_value <= ERRVAL_RST;
            err_limit <= ERRCNT_RST;
            dip_ms <= DIP_RST;
            offset <= OFFSET_RST;
            area_start <= '0;
            area_end <= '0;
            area_on <= 1'b0;
            cfg_reject <= 1'b0;
            nvm_store <= 1'b0;
            reflect_excl <= 1'b0;
        end
        else
        begin
            nvm_store <= cmd_wr && reg_wdata[CMD_STORE];
            reflect_excl <= ctrl.reflect;
            // set wins over clear
            if (ctrl_wr && !ctrl_ok)
                cfg_reject <= 1'b1;
            else if (cmd_wr && reg_wdata[CMD_CLR_REJ])
                cfg_reject <= 1'b0;
            if (restore)
            begin
                ctrl <= CTRL_RST;
                err_value <= ERRVAL_RST;
                err_limit <= ERRCNT_RST;
                dip_ms <= DIP_RST;
                offset <= OFFSET_RST;
                area_on <= 1'b0;
            end
            else
            begin
                if (ctrl_wr && ctrl_ok)
                begin
                    ctrl <= cfg_new;
                    if (cfg_new.reverse != ctrl.reverse)
                        offset <= STROKE - offset;
                end
                if (reg_wr && reg_addr == ERRVAL_ADDR)
                    err_value <= reg_wdata[POS_W-1:0];
                if (reg_wr && reg_addr == ERRCNT_ADDR)
                    err_limit <= reg_wdata[7:0];
                if (reg_wr && reg_addr == DIP_ADDR)
                    dip_ms <= reg_wdata[6:0];
                if (reg_wr && reg_addr == OFFSET_ADDR)
                    offset <= reg_wdata[POS_W-1:0];
                if (cmd_wr && reg_wdata[CMD_SET_OFS])
                    offset <= last_p1;
                if (cmd_wr && reg_wdata[CMD_SET_START])
                    area_start <= last_p1;
                if (cmd_wr && reg_wdata[CMD_SET_END])
                    area_end <= last_p1;
                if (cmd_wr && (reg_wdata[CMD_SET_START] || reg_wdata[CMD_SET_END]))
                    area_on <= 1'b1;
                if (cmd_wr && reg_wdata[CMD_CLR_AREA])
                    area_on <= 1'b0;
            end
        end
    end

    // ============================================================
    // read data, valid only in the cycle after the strobe
    logic [31:0] rd_mux;
    assign rd_mux = (reg_addr == CTRL_ADDR) ? 32'(ctrl) :
                    (reg_addr == ERRVAL_ADDR) ? 32'(err_value) :
                    (reg_addr == ERRCNT_ADDR) ? 32'(err_limit) :
                    (reg_addr == DIP_ADDR) ? 32'(dip_ms) :
                    (reg_addr == OFFSET_ADDR) ? 32'(offset) :
                    (reg_addr == AREA_S_ADDR) ? 32'(area_start) :
                    (reg_addr == AREA_E_ADDR) ? 32'(area_end) :
                    (reg_addr == STATUS_ADDR) ?
                        {28'h0, err_active, area_on, state != SSI_IDLE, cfg_reject} :
                    (reg_addr == POS_ADDR) ? 32'(out_value) : 32'h0;

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            reg_rdata <= '0;
        else
            reg_rdata <= reg_rd ? rd_mux : 32'h0;
    end

    // ============================================================
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    reject_both_a: assert property (ctrl_wr && wr_cfg.parity_en && wr_cfg.temp_en && !restore
        |=> ctrl == $past(ctrl) && cfg_reject) else $error("bad config taken");
    mode3_dep_a: assert property (ctrl.sync3 |-> ctrl.oversampled_sync_select)
        else $error("mode 3 without mode 2");
    mode2_dep_a: assert property (ctrl.oversampled_sync_select |-> ctrl.polled_timing_select)
        else $error("mode 2 without polled timing");
    width_sel_a: assert property (!ctrl.temp_en |-> frame_len inside {6'd24, 6'd25, 6'd26})
        else $error("bad word width");
    burst_latch_a: assert property (latch && !mono_end |=> state == SSI_SHIFT
        && shreg == $past(frame)) else $error("burst not latched");
    polled_start_a: assert property (latch && !free_run |=> meas_start)
        else $error("no start at burst");
    dir_offset_a: assert property (ctrl_wr && ctrl_ok && !restore
        && wr_cfg.reverse != ctrl.reverse && !cmd_wr
        |=> offset == STROKE - $past(offset)) else $error("offset not converted");
    set_offset_a: assert property (cmd_wr && reg_wdata[CMD_SET_OFS] && !restore
        |=> offset == $past(last_p1)) else $error("offset not captured");
    idle_high_a: assert property (state == SSI_IDLE ##1 state == SSI_IDLE |-> ssi_data)
        else $error("data low while idle");

    burst_done_c: cover property (state == SSI_TAIL ##1 state == SSI_IDLE);
    error_out_c: cover property (!err_active ##1 err_active);
    reject_c: cover property (ctrl_wr && !ctrl_ok);
    dip_c: cover property (meas.valid && !good && dip_hold);

endmodule // spo_ssi_output

//--- spo_pkg.sv
// shared constants and types of the position output processor
package spo_pkg;

    // ============================================================
    // widths and timing
    localparam int POS_W = 26;
    localparam int FRAME_W = 32;
    localparam int CLK_NS = 20;
    localparam int MONO_NS = 20000;
    // least time, so round up
    localparam int MONO_CYC = (MONO_NS + CLK_NS - 1) / CLK_NS;
    localparam int MS_NS = 1000000;
    localparam int MS_CYC = MS_NS / CLK_NS;

    // ============================================================
    // register offsets
    localparam logic [7:0] CTRL_ADDR = 8'h00;
    localparam logic [7:0] ERRVAL_ADDR = 8'h04;
    localparam logic [7:0] ERRCNT_ADDR = 8'h08;
    localparam logic [7:0] DIP_ADDR = 8'h0c;
    localparam logic [7:0] OFFSET_ADDR = 8'h10;
    localparam logic [7:0] AREA_S_ADDR = 8'h14;
    localparam logic [7:0] AREA_E_ADDR = 8'h18;
    localparam logic [7:0] CMD_ADDR = 8'h1c;
    localparam logic [7:0] STATUS_ADDR = 8'h20;
    localparam logic [7:0] POS_ADDR = 8'h24;

    // command bit positions
    localparam int CMD_SET_OFS = 0;
    localparam int CMD_STORE = 1;
    localparam int CMD_RESTORE = 2;
    localparam int CMD_SET_START = 3;
    localparam int CMD_SET_END = 4;
    localparam int CMD_CLR_AREA = 5;
    localparam int CMD_CLR_REJ = 6;

    // output selection and width codes
    localparam logic [1:0] OUT_POS = 2'h0;
    localparam logic [1:0] OUT_DIFF = 2'h1;
    localparam logic [1:0] OUT_VEL = 2'h2;
    localparam logic [1:0] WSEL_BAD = 2'h3;

    // ============================================================
    // types
    typedef struct packed {
        logic [1:0] filt;
        logic [1:0] out_sel;
        logic second_err;
        logic reverse;
        logic reflect;
        logic sync3;
        logic oversampled_sync_select;
        logic polled_timing_select;
        logic temp_en;
        logic parity_en;
        logic [1:0] wsel;
        logic gray;
    } spo_cfg_s;

    localparam int CFG_W = $bits(spo_cfg_s);

    typedef struct packed {
        logic valid;
        logic fail;
        logic [1:0] magnets;
        logic [POS_W-1:0] pos1;
        logic [POS_W-1:0] pos2;
        logic [7:0] temp;
    } spo_meas_s;

    typedef enum logic [2:0] {
        SSI_IDLE = 3'b001,
        SSI_SHIFT = 3'b010,
        SSI_TAIL = 3'b100
    } spo_ssi_e;

    // factory values
    localparam spo_cfg_s CTRL_RST = '0;
    localparam logic [POS_W-1:0] ERRVAL_RST = 26'h0000000;
    localparam logic [7:0] ERRCNT_RST = 8'h01;
    localparam logic [6:0] DIP_RST = 7'h00;
    localparam logic [POS_W-1:0] OFFSET_RST = 26'h0000000;

endpackage

//--- spo_avg_filter.sv
// moving average over the newest 1, 2, 4 or 8 results
`timescale 1ns/10ps
module spo_avg_filter
    import spo_pkg::*;
#(
    parameter int W = POS_W,
    parameter int DEPTH = 8
)
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic in_valid,
    input wire logic signed [W-1:0] in_data,
    input wire logic [1:0] sel,
    output logic out_valid,
    output logic signed [W-1:0] out_data
);

    if (DEPTH != 8)
    begin : g_chk
        $error("filter depth must be 8");
    end

    logic signed [W-1:0] hist [DEPTH-1];
    logic signed [W+2:0] sum;

    // ============================================================
    // sum of the newest sample and the history it displaces into
    always_comb
    begin
        sum = (W+3)'(in_data);
        for (int i = 0; i < DEPTH - 1; i++)
        begin
            if (i < (1 << sel) - 1)
                sum = sum + (W+3)'(hist[i]);
        end
    end

    // history starts at zero, so the first few averages lean toward zero
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            for (int i = 0; i < DEPTH - 1; i++)
                hist[i] <= '0;
            out_valid <= 1'b0;
            out_data <= '0;
        end
        else
        begin
            out_valid <= in_valid;
            if (in_valid)
            begin
                hist[0] <= in_data;
                for (int i = 1; i < DEPTH - 1; i++)
                    hist[i] <= hist[i-1];
                out_data <= W'(sum >>> sel);
            end
        end
    end

endmodule // spo_avg_filter

//--- spo_ssi_master.sv
// controller model that clocks serial frames out of the block
`timescale 1ns/10ps
module spo_ssi_master
(
    output logic ssi_clk,
    input wire logic ssi_data
);
    logic [31:0] word;
    // ============================================================
    // idle high between bursts
    initial ssi_clk = 1'b1;
    // n+1 pulses; the first fall latches the frame, and the first bit is read in the second pulse
    task automatic burst(input int n);
        // step off the system clock edges so no edge races the sampling flop
        #5;
        word = '0;
        for (int i = 0; i <= n; i++)
        begin
            ssi_clk = 1'b0;
            #80;
            if (i > 0)
                word = {word[30:0], ssi_data};
            ssi_clk = 1'b1;
            #80;
        end
        // clock stays high past the monoflop so the next burst is fresh
        #30000;
    endtask
endmodule // spo_ssi_master

//--- spo_ssi_output_tb_top.sv
// self-checking bench of the position output processor
`timescale 1ns/10ps
module spo_ssi_output_tb_top;
    import spo_pkg::*;
    localparam logic [25:0] V = 26'h00c5a3b;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    spo_meas_s meas = '0;
    logic ssi_clk;
    logic ssi_data;
    logic supply_ok = 1'b1;
    logic meas_start;
    logic reflect_excl;
    logic nvm_store;
    int err_total = 0;
    int n_compared = 0;
    int n_start = 0;
    // ============================================================
    // clock and instances
    always #10 ref_clk = ~ref_clk;
    spo_ssi_output #(.MS_CYCLES(20)) spo_ssi_output_i (.ref_clk(ref_clk),
        .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .meas(meas),
        .supply_ok(supply_ok), .ssi_clk(ssi_clk), .ssi_data(ssi_data),
        .meas_start(meas_start), .reflect_excl(reflect_excl), .nvm_store(nvm_store));
    spo_ssi_master spo_ssi_master_i (.ssi_clk(ssi_clk), .ssi_data(ssi_data));
    // counts start pulses; scenarios compare the count before and after
    always @(posedge ref_clk)
    begin
        if (meas_start === 1'b1)
            n_start <= n_start + 1;
    end
    // ============================================================
    // shared tasks
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e)
        begin
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
            err_total++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        chk(reg_rdata, e);
    endtask
    task automatic feed(input logic [1:0] m, input logic [25:0] p);
        @(posedge ref_clk);
        meas <= '{1'b1, 1'b0, m, p, 26'h0, 8'h5a};
        @(posedge ref_clk);
        meas.valid <= 1'b0;
        repeat (4) @(posedge ref_clk);
    endtask
    task automatic frame(input int n, input logic [31:0] e);
        spo_ssi_master_i.burst(n);
        chk(spo_ssi_master_i.word, e);
    endtask
    // ============================================================
    // scenarios
    task automatic t_reject();
        rd(CTRL_ADDR, 32'h0);
        rd(ERRCNT_ADDR, 32'h1);
        rd(8'h30, 32'h0);
        wr(CTRL_ADDR, 32'h18);
        rd(STATUS_ADDR, 32'h1);
        rd(CTRL_ADDR, 32'h0);
        $display("reset and reject test done");
    endtask
    task automatic t_frame();
        wr(CTRL_ADDR, 32'h4);
        feed(2'h1, V);
        rd(POS_ADDR, {6'h0, V});
        frame(26, {6'h0, V});
        wr(CTRL_ADDR, 32'h1);
        frame(24, {8'h0, V[23:0] ^ V[24:1]});
        wr(CTRL_ADDR, 32'h10);
        frame(32, {V[23:0], 8'h5a});
        wr(CTRL_ADDR, 32'h8);
        frame(26, {6'h0, V[23:0], 1'b0, ^V[23:0]});
        $display("frame test done");
    endtask
    // old value repeats once, then the error value takes over
    task automatic t_error();
        int s;
        wr(CTRL_ADDR, 32'h0);
        wr(ERRVAL_ADDR, 32'h3ff);
        // two failures inside the dip window must leave no trace
        wr(DIP_ADDR, 32'h2);
        supply_ok <= 1'b0;
        repeat (2) @(posedge ref_clk);
        s = n_start;
        feed(2'h0, 26'h1);
        chk(n_start - s, 32'h1);
        feed(2'h0, 26'h1);
        supply_ok <= 1'b1;
        rd(POS_ADDR, {6'h0, V});
        feed(2'h0, 26'h1);
        rd(POS_ADDR, {6'h0, V});
        feed(2'h0, 26'h1);
        rd(POS_ADDR, 32'h3ff);
        wr(CTRL_ADDR, 32'h400);
        feed(2'h2, 26'h1);
        rd(POS_ADDR, 32'hffffffff);
        $display("error test done");
    endtask
    // front end requests, store and restore, polled start
    task automatic t_ctrl();
        int s;
        wr(CTRL_ADDR, 32'h100);
        rd(CTRL_ADDR, 32'h100);
        chk(reflect_excl, 32'h1);
        wr(CMD_ADDR, 32'h2);
        @(negedge ref_clk);
        chk(nvm_store, 32'h1);
        wr(CMD_ADDR, 32'h4);
        rd(CTRL_ADDR, 32'h0);
        chk(nvm_store, 32'h0);
        wr(CTRL_ADDR, 32'h24);
        s = n_start;
        frame(26, {6'h0, V});
        chk(n_start - s, 32'h1);
        $display("control test done");
    endtask
    // offset, direction and averaging, expected values worked by hand
    task automatic t_calc();
        wr(OFFSET_ADDR, 32'h100);
        feed(2'h1, V);
        rd(POS_ADDR, {6'h0, V - 26'h100});
        wr(CTRL_ADDR, 32'h200);
        feed(2'h1, 26'h400);
        rd(POS_ADDR, 32'hfffffd00);
        wr(CMD_ADDR, 32'h1);
        feed(2'h1, 26'h400);
        rd(POS_ADDR, 32'h0);
        wr(CTRL_ADDR, 32'h2200);
        feed(2'h1, 26'h300);
        rd(POS_ADDR, 32'h80);
        $display("calc test done");
    endtask
    task automatic print_verdict();
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // ============================================================
    // main sequence and watchdog
    initial
    begin
        repeat (4) @(posedge ref_clk);
        reset_n <= 1'b1;
        t_reject();
        t_frame();
        t_ctrl();
        t_error();
        t_calc();
        print_verdict();
    end
    initial
    begin
        #500000;
        err_total++;
        print_verdict();
    end
endmodule // spo_ssi_output_tb_top
